// ### hdl/comp_timer_map.vh
// register map, field positions and constants of the composite timer
// Overview of operation
// R1: writing one to the start bit restarts the counter from 00 hex (01 hex in fixed-cycle pwm mode) on the selected count clock.
// R2: in continuous mode a match toggles the output, sets the flag and clears the counter.
// R3: in free-run mode a match toggles the output and sets the flag; the counter wraps at its top.
// R4: the compare latch loads the compare data at start and at every match.
// R5: in the interval modes a stopped timer keeps its last output level.
// R6: in fixed-cycle pwm mode the period is a full count of FF or FFFF hex.
// R7: in fixed-cycle pwm mode the compare data sets the high width and each cycle starts high.
// R8: fixed-cycle pwm mode never sets the interrupt flag.
// R9: fixed-cycle pwm mode ignores the output initial-level bit.
// R10: the first pwm high pulse after start is one count clock shorter than programmed.
// R11: software selects the mode by function field 0001, 0010 or 0011 in control a.
// R12: the pwm wave appears on the output pin of the counter in use.
// R13: in 16-bit mode the upper compare byte is buffered and moves up when the lower is written.
// R14: the three-bit clock select field of control a picks the count clock divider.
`ifndef COMP_TIMER_MAP_VH
`define COMP_TIMER_MAP_VH

// ----------------------------------------------------------------
// register groups: addr[6:4] picks the group, addr[3:2] the unit
// ----------------------------------------------------------------
`define GRP_CTRL_A 3'h0
`define GRP_CTRL_B 3'h1
`define GRP_DATA 3'h2
`define GRP_MODE 3'h3
`define GRP_IRQ 3'h4
`define IDX_STATUS 2'h0
`define IDX_MASK 2'h1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CA_IFE 7
`define CA_CSEL_MSB 6
`define CA_CSEL_LSB 4
`define CA_FUNC_MSB 3
`define CA_FUNC_LSB 0
`define CB_STA 7
`define CB_IR 4
`define CB_BF 3
`define CB_IF 2
`define CB_SO 1
`define CB_OE 0
`define MD_TO1 7
`define MD_TO0 6
`define MD_WIDTH 4
`define CB_RW_MASK 8'hE3

// ----------------------------------------------------------------
// function codes, counts and reset values
// ----------------------------------------------------------------
`define FUNC_CONT 4'h1
`define FUNC_FREE 4'h2
`define FUNC_PWM 4'h3
`define TOP8 16'h00FF
`define TOP16 16'hFFFF
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define REG_RESET 8'h00
`define PRESCALE_W 7

`endif

// ### hdl/count_clock_prescaler.v
// count clock prescaler: one tick per selected division of pclk
`timescale 1ns/1ps
`include "comp_timer_map.vh"

module count_clock_prescaler
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// tick k fires once every 2**k cycles
	output reg [7:0] tick
);

reg [`PRESCALE_W-1:0] free_cnt;
wire [7:0] next_tick;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		free_cnt <= {`PRESCALE_W{1'b0}};
	else
		free_cnt <= free_cnt + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
end

assign next_tick[0] = 1'b1;

genvar k;
generate
	for (k = 1; k < 8; k = k + 1)
	begin : div
		assign next_tick[k] = &free_cnt[k-1:0];
	end
endgenerate

// one register drives every tick bit
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		tick <= 8'h00;
	else
		tick <= next_tick;
end

endmodule

// ### hdl/composite_timer.v
// dual-channel 8/16-bit composite timer with apb register access
`timescale 1ns/1ps
`include "comp_timer_map.vh"

module composite_timer
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg pready,
	output reg [31:0] prdata,
	output reg pslverr,
	// timer output pins
	output wire ch0_lower_output_pin,
	output wire ch0_upper_output_pin,
	output wire ch1_lower_output_pin,
	output wire ch1_upper_output_pin,
	// interrupt
	output reg irq
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function mode_ok;
	input [3:0] fsel;
	begin
		mode_ok = (fsel == `FUNC_CONT) || (fsel == `FUNC_FREE) || (fsel == `FUNC_PWM);
	end
endfunction

function addr_mapped;
	input [31:0] addr;
	begin
		case (addr[6:4])
			`GRP_CTRL_A, `GRP_CTRL_B, `GRP_DATA:
				addr_mapped = 1'b1;
			`GRP_MODE:
				addr_mapped = ~addr[3];
			`GRP_IRQ:
				addr_mapped = (addr[3:2] == `IDX_STATUS) || (addr[3:2] == `IDX_MASK);
			default:
				addr_mapped = 1'b0;
		endcase
		addr_mapped = addr_mapped && (addr[31:7] == 25'h0000000) && (addr[1:0] == 2'h0);
	end
endfunction

// ----------------------------------------------------------------
// register storage
// ----------------------------------------------------------------
reg [7:0] ctrl_a [0:3];
reg [7:0] ctrl_b [0:3];
reg [7:0] cmp_data [0:3];
reg [7:0] mode_reg [0:1];
reg [7:0] wr_buf [0:1];
reg [3:0] status;
reg [3:0] mask;
reg [3:0] pin_q;

wire [7:0] tick_all;
wire [3:0] tick;
wire [3:0] hit_vec;
wire [3:0] out_vec;
wire [3:0] oe_vec;
wire [1:0] unit_idx;
wire grp_ok;
wire acc_done;
wire wr_en;
wire status_clr;

reg [7:0] rd_byte;

assign unit_idx = paddr[3:2];
assign grp_ok = addr_mapped(paddr);
assign acc_done = psel && penable && pready;
assign wr_en = acc_done && pwrite && grp_ok;
assign status_clr = wr_en && (paddr[6:4] == `GRP_IRQ) && (unit_idx == `IDX_STATUS);

// ----------------------------------------------------------------
// count clock source
// ----------------------------------------------------------------
count_clock_prescaler u_prescaler
(
	.pclk(pclk),
	.presetn(presetn),
	.tick(tick_all)
);

// ----------------------------------------------------------------
// apb handshake: one wait state, answer from flip-flops
// ----------------------------------------------------------------
always @*
begin
	rd_byte = `REG_RESET;
	case (paddr[6:4])
		`GRP_CTRL_A:
			rd_byte = ctrl_a[unit_idx];
		`GRP_CTRL_B:
			rd_byte = (ctrl_b[unit_idx] & `CB_RW_MASK) | ({7'h00, status[unit_idx]} << `CB_IF);
		`GRP_DATA:
			rd_byte = cmp_data[unit_idx];
		`GRP_MODE:
			rd_byte = {out_vec[{paddr[2], 1'b1}], out_vec[{paddr[2], 1'b0}],
				mode_reg[paddr[2]][5:0]};
		`GRP_IRQ:
			rd_byte = (unit_idx == `IDX_STATUS) ? {4'h0, status} : {4'h0, mask};
		default:
			rd_byte = `REG_RESET;
	endcase
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pready <= 1'b0;
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end
	else
	begin
		pready <= psel && penable && !pready;
		pslverr <= psel && penable && !pready && !grp_ok;
		if (psel && penable && !pready && !pwrite && grp_ok)
			prdata <= {24'h000000, rd_byte};
		else
			prdata <= 32'h00000000;
	end
end

// ----------------------------------------------------------------
// register writes
// ----------------------------------------------------------------
integer i;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		for (i = 0; i < 4; i = i + 1)
		begin
			ctrl_a[i] <= `REG_RESET;
			ctrl_b[i] <= `REG_RESET;
			cmp_data[i] <= `REG_RESET;
		end
		for (i = 0; i < 2; i = i + 1)
		begin
			mode_reg[i] <= `REG_RESET;
			wr_buf[i] <= `REG_RESET;
		end
		mask <= 4'h0;
	end
	else if (wr_en)
	begin
		case (paddr[6:4])
			`GRP_CTRL_A:
				ctrl_a[unit_idx] <= pwdata[7:0];
			`GRP_CTRL_B:
				ctrl_b[unit_idx] <= pwdata[7:0] & `CB_RW_MASK;
			`GRP_DATA:
			begin
				if (mode_reg[unit_idx[1]][`MD_WIDTH] && unit_idx[0])
					wr_buf[unit_idx[1]] <= pwdata[7:0]; // R13
				else if (mode_reg[unit_idx[1]][`MD_WIDTH])
				begin
					cmp_data[unit_idx] <= pwdata[7:0]; // R13
					cmp_data[{unit_idx[1], 1'b1}] <= wr_buf[unit_idx[1]]; // R13
				end
				else
					cmp_data[unit_idx] <= pwdata[7:0];
			end
			`GRP_MODE:
				mode_reg[paddr[2]] <= {2'b00, pwdata[5:0]};
			`GRP_IRQ:
				if (unit_idx == `IDX_MASK)
					mask <= pwdata[3:0];
			default:
				mask <= mask;
		endcase
	end
end

// ----------------------------------------------------------------
// interrupt status: set wins over write-one-to-clear
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		status <= 4'h0;
		irq <= 1'b0;
	end
	else
	begin
		if (status_clr)
			status <= (status & ~pwdata[3:0]) | hit_vec;
		else
			status <= status | hit_vec;
		irq <= |(status & mask);
	end
end

// ----------------------------------------------------------------
// counter units: 0/1 lower/upper of channel 0, 2/3 of channel 1
// ----------------------------------------------------------------
genvar u;
generate
	for (u = 0; u < 4; u = u + 1)
	begin : unit
		localparam integer LO = (u / 2) * 2;
		wire wide;
		wire idle;
		wire run;
		wire [3:0] fsel;
		wire [2:0] csel;
		wire [15:0] top;
		wire [15:0] data;
		wire [15:0] next_cnt;
		reg [15:0] cnt;
		reg [15:0] cmp;
		reg out_bit;
		reg run_d;
		reg hit;

		assign wide = mode_reg[u / 2][`MD_WIDTH];
		assign idle = wide && (u != LO);
		assign fsel = ctrl_a[u][`CA_FUNC_MSB:`CA_FUNC_LSB];
		assign csel = ctrl_a[u][`CA_CSEL_MSB:`CA_CSEL_LSB];
		assign run = ctrl_b[u][`CB_STA] && !idle && mode_ok(fsel); // R11
		assign top = wide ? `TOP16 : `TOP8; // R6
		assign data = wide ? {cmp_data[LO + 1], cmp_data[LO]} : {8'h00, cmp_data[u]};
		assign next_cnt = (cnt == top) ? `CNT_ZERO : cnt + `CNT_ONE;
		assign tick[u] = tick_all[csel]; // R14
		assign hit_vec[u] = hit;
		assign out_vec[u] = out_bit;
		assign oe_vec[u] = ctrl_b[u][`CB_OE];

		always @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				cnt <= `CNT_ZERO;
				cmp <= `CNT_ZERO;
				out_bit <= 1'b0;
				run_d <= 1'b0;
				hit <= 1'b0;
			end
			else
			begin
				run_d <= run;
				hit <= 1'b0;
				if (run && !run_d)
				begin
					cmp <= data; // R4
					// pwm counts the start edge itself, so its first high pulse is one short
					if (fsel == `FUNC_PWM)
					begin
						cnt <= `CNT_ONE; // R10
						out_bit <= 1'b1; // R9
					end
					else
					begin
						cnt <= `CNT_ZERO; // R1
						out_bit <= ctrl_b[u][`CB_SO];
					end
				end
				else if (run && tick[u])
				begin
					case (fsel)
						`FUNC_CONT:
						begin
							if (cnt == cmp)
							begin
								out_bit <= ~out_bit; // R2
								hit <= 1'b1; // R2
								cnt <= `CNT_ZERO; // R2
								cmp <= data; // R4
							end
							else
								cnt <= next_cnt;
						end
						`FUNC_FREE:
						begin
							cnt <= next_cnt; // R3
							if (cnt == cmp)
							begin
								out_bit <= ~out_bit; // R3
								hit <= 1'b1; // R3
								cmp <= data; // R4
							end
						end
						`FUNC_PWM:
						begin
							cnt <= next_cnt; // R6
							if (next_cnt == cmp)
							begin
								out_bit <= 1'b0; // R7 R8 R10
								cmp <= data; // R4
							end
							else if (cnt == top)
								out_bit <= 1'b1; // R7
						end
						default:
							cnt <= cnt;
					endcase
				end
				else
					out_bit <= out_bit; // R5
			end
		end
	end
endgenerate

// ----------------------------------------------------------------
// output pins: driven while output enable is set
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		pin_q <= 4'h0;
	else
		pin_q <= out_vec & oe_vec; // R12
end

assign ch0_lower_output_pin = pin_q[0];
assign ch0_upper_output_pin = pin_q[1];
assign ch1_lower_output_pin = pin_q[2];
assign ch1_upper_output_pin = pin_q[3];

endmodule

// ### tb/timer_port_checker.sv
// port assertions for the composite timer
`timescale 1ns/1ps

module timer_port_checker
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb and interrupt
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_one_wait:
	assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not two edges after setup");
	chk_ready_pulse:
	assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_cause:
	assert property (pready |-> psel && penable && $past(penable))
		else $error("pready without access phase");
	chk_err_ready:
	assert property (pslverr |-> pready)
		else $error("pslverr outside pready");
	chk_err_unmapped:
	assert property (pready && paddr[31:7] != 25'h0 |-> pslverr)
		else $error("unmapped address not refused");
	chk_mapped_ok:
	assert property (pready && paddr == 32'h40 |-> !pslverr)
		else $error("status access refused");
	chk_read_byte:
	assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_mask_quiet:
	assert property (pready && pwrite && paddr == 32'h44 && pwdata[3:0] == 4'h0 |-> ##2 !irq)
		else $error("irq high with mask clear");
endmodule

bind composite_timer timer_port_checker chk_inst
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .irq(irq)
);

// ### tb/tb_top.sv
// self-checking bench for the composite timer
`timescale 1ns/1ps
`include "comp_timer_map.vh"
`define CHK(a, b) \
	begin \
		n_tests++; \
		if ((a) !== (b)) \
		begin \
			error_cnt++; \
			$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); \
		end \
	end

module tb_top;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [31:0] paddr = 32'h0;
	reg [31:0] pwdata = 32'h0;
	reg [31:0] rd;
	reg [24:0] rows [0:5];
	wire pready;
	wire pslverr;
	wire irq;
	wire [31:0] prdata;
	wire [3:0] pin;
	int error_cnt = 0;
	int n_tests = 0;
	int n;

	composite_timer uut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.ch0_lower_output_pin(pin[0]), .ch0_upper_output_pin(pin[1]),
		.ch1_lower_output_pin(pin[2]), .ch1_upper_output_pin(pin[3]), .irq(irq)
	);

	initial
	begin
		forever #2 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic apb(input bit wr, input [7:0] a, input [7:0] d, input bit err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {24'h0, a};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			stop_test;
		end
		rd = prdata;
		`CHK(pslverr, err)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task w(input [7:0] a, input [7:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask

	task r(input [7:0] a, input [7:0] e);
		apb(1'b0, a, 8'h00, 1'b0);
		`CHK(rd[7:0], e)
	endtask

	// counts cycles the pin keeps its present level
	task automatic span(input int k);
		bit v;
		v = pin[k];
		n = 0;
		while (pin[k] === v && n < 2000)
		begin
			n++;
			@(negedge pclk);
		end
		if (n >= 2000)
		begin
			error_cnt++;
			stop_test;
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rows = '{25'h0007171, 25'h0107F63, 25'h030EF2F, 25'h020A5A5, 25'h0440F0F,
			25'h180FF00};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			apb(1'b0, rows[k][23:16], 8'h00, rows[k][24]);
			`CHK(rd[7:0], 8'h00)
			apb(1'b1, rows[k][23:16], rows[k][15:8], rows[k][24]);
			apb(1'b0, rows[k][23:16], 8'h00, rows[k][24]);
			`CHK(rd[7:0], rows[k][7:0])
		end
		$display("register rows done");
		w(8'h20, 8'h02);
		w(8'h00, {4'h0, `FUNC_CONT});
		w(8'h10, 8'h81);
		repeat (2) span(0);
		`CHK(n, 3)
		w(8'h20, 8'h05);
		repeat (3) span(0);
		`CHK(n, 6)
		// stop just after a rising edge so the held level is high
		if (pin[0] === 1'b1)
			span(0);
		span(0);
		w(8'h10, 8'h01);
		repeat (4) @(posedge pclk);
		`CHK(pin[0], 1'b1)
		r(8'h30, 8'h6F);
		`CHK(irq, 1'b1)
		r(8'h40, 8'h01);
		w(8'h44, 8'h00);
		r(8'h40, 8'h01);
		`CHK(irq, 1'b0)
		w(8'h40, 8'h0F);
		r(8'h40, 8'h00);
		$display("continuous done");
		w(8'h24, 8'h10);
		w(8'h04, {4'h0, `FUNC_FREE});
		w(8'h14, 8'h81);
		repeat (2) span(1);
		`CHK(n, 256)
		w(8'h14, 8'h01);
		w(8'h40, 8'h0F);
		$display("free-run done");
		w(8'h28, 8'h40);
		w(8'h08, {4'h0, `FUNC_PWM});
		w(8'h18, 8'h81);
		span(2);
		span(2);
		`CHK(n, 63)
		span(2);
		`CHK(n, 192)
		span(2);
		`CHK(n, 64)
		r(8'h40, 8'h00);
		w(8'h18, 8'h01);
		$display("pwm done");
		w(8'h34, 8'h10);
		w(8'h2C, 8'h01);
		r(8'h2C, 8'h00);
		w(8'h28, 8'h02);
		r(8'h2C, 8'h01);
		w(8'h08, {4'h1, `FUNC_CONT});
		w(8'h18, 8'h81);
		repeat (3) span(2);
		`CHK(n, 518)
		$display("16-bit done");
		w(8'h44, 8'h04);
		repeat (2) @(negedge pclk);
		`CHK(irq, 1'b1)
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		`CHK(irq, 1'b0)
		`CHK(pin, 4'h0)
		@(posedge pclk);
		presetn <= 1'b1;
		r(8'h18, 8'h00);
		$display("reset done");
		stop_test;
	end
endmodule
